// [pkg/aix_pkg.sv]
package aix_pkg;
   // special function register bus
   localparam int SFR_AW = 8;
   localparam int SFR_DW = 8;
   localparam logic [7:0] ADDR_TCTL = 8'h88;
   localparam logic [7:0] ADDR_XFLG = 8'h91;
   localparam logic [7:0] ADDR_AIPL = 8'hA4;
   localparam logic [7:0] ADDR_PIDX = 8'hA5;
   localparam logic [7:0] ADDR_AIEN = 8'hA6;
   localparam logic [7:0] ADDR_AIST = 8'hA7;
   localparam logic [7:0] ADDR_PIEN = 8'hA8;
   localparam logic [7:0] ADDR_PSEL = 8'hB8;
   localparam logic [7:0] ADDR_EICN = 8'hD8;
   localparam logic [7:0] ADDR_EMSK = 8'hE8;

   // reset values
   localparam logic [7:0] PIEN_RST = 8'h00;
   localparam logic [7:0] PSEL_RST = 8'h00;
   localparam logic [7:0] TCTL_RST = 8'h00;
   localparam logic [7:0] EICN_RST = 8'h00;
   localparam logic [7:0] EMSK_RST = 8'h00;
   localparam logic [7:0] AIEN_RST = 8'h00;
   // edge detector idle levels: rising extra inputs idle high, falling extra inputs low, inputs zero and one high
   localparam logic [3:0] EPRV_RST = 4'h5;
   localparam logic [1:0] XPRV_RST = 2'h3;

   // extra edge inputs two..five: bit set means rising-edge sensitive
   localparam logic [3:0] EDGE_RISE = 4'h5;
   localparam int XFLG_LSB = 4;

   // primary enable fields
   localparam int PIEN_GLOBAL = 7;

   // timer control fields
   localparam int TCTL_IT0 = 0;
   localparam int TCTL_IE0 = 1;
   localparam int TCTL_IT1 = 2;
   localparam int TCTL_IE1 = 3;
   localparam int TCTL_TR0 = 4;
   localparam int TCTL_TF0 = 5;
   localparam int TCTL_TR1 = 6;
   localparam int TCTL_TF1 = 7;

   // enable interrupt control fields
   localparam int EICN_WDOG = 3;
   localparam int EICN_SUM = 4;
   localparam int EICN_MEN = 5;
   localparam int EICN_SMOD1 = 7;

   // auxiliary source positions, bit 0 has the highest priority
   localparam int AUX_SEC = 0;
   localparam int AUX_ADSUM = 1;
   localparam int AUX_ADC = 2;
   localparam int AUX_MSEC = 3;
   localparam int AUX_SPITX = 4;
   localparam int AUX_SPIRX = 5;
   localparam int AUX_ALVD = 6;
   localparam int AUX_DLVD = 7;
   localparam int AUX_N = 8;
   localparam logic [3:0] PIDX_BASE = 4'h1;
   localparam logic [15:0] AUX_VECTOR = 16'h0033;
endpackage

// [pkg/aix_aux_if.sv]
interface aix_aux_if;
   import aix_pkg::*;
   logic [AUX_N-1:0] raw;
   logic [AUX_N-1:0] enable;
   logic [AUX_N-1:0] masked;
   logic [3:0] index;
   modport core (output raw, output enable, input masked, input index);
   modport prio (input raw, input enable, output masked, output index);
endinterface

// [hdl/aix_aux_prio.sv]
module aix_aux_prio
(
   // source status in, masked status and index out
   aix_aux_if.prio aux
);
   import aix_pkg::*;

   // lowest set bit wins; zero code when nothing is pending
   function automatic logic [3:0] aix_encode(input logic [AUX_N-1:0] pend);
      logic [3:0] code;
      code = 4'h0;
      for (int i = AUX_N - 1; i >= 0; i--)
      begin
         if (pend[i])
         begin
            code = PIDX_BASE + 4'(i);
         end
      end
      return code;
   endfunction

   // purely combinational so the index never lags the masked status
   always_comb
   begin
      aux.masked = aux.raw & aux.enable;
      aux.index = aix_encode(aux.raw & aux.enable);
   end
endmodule // aix_aux_prio

// [hdl/aix_irq_ctrl.sv]
module aix_irq_ctrl
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // special function register port
   input wire logic [aix_pkg::SFR_AW-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [aix_pkg::SFR_DW-1:0] sfr_wdata,
   output logic [aix_pkg::SFR_DW-1:0] sfr_rdata,
   // interrupt sources
   input wire logic [3:0] edge_in,
   input wire logic ext_input_zero,
   input wire logic ext_input_one,
   input wire logic tmr0_ovf,
   input wire logic tmr1_ovf,
   input wire logic watchdog_evt,
   input wire logic [aix_pkg::AUX_N-1:0] aux_src,
   // requests and settings toward the core
   output logic [3:0] ext_irq_req,
   output logic aux_irq_req,
   output logic [15:0] aux_vector,
   output logic [7:0] prim_enable,
   output logic [7:0] priority_select,
   output logic [1:0] timer_run,
   output logic serial1_dbl_rate
);
   import aix_pkg::*;

   typedef struct packed {
      logic [7:0] pien;
      logic [7:0] psel;
      logic [7:0] tctl;
      logic [7:0] eicn;
      logic [7:0] emsk;
      logic [7:0] aien;
      logic [3:0] eflag;
      logic [3:0] eprev;
      logic [1:0] xprev;
      logic [7:0] rdata;
      logic aux_req;
      logic [3:0] ext_req;
   } aix_state_t;

   aix_state_t st_reg;
   aix_state_t st_next;
   aix_aux_if aux ();

   // per-input edge hit, polarity chosen by the rise mask
   function automatic logic [3:0] aix_edge(input logic [3:0] cur,
                                           input logic [3:0] prev);
      return (cur & ~prev & EDGE_RISE) | (~cur & prev & ~EDGE_RISE);
   endfunction

   // priority encoder and masking shared with the read path
   assign aux.raw = aux_src;
   assign aux.enable = st_reg.aien;

   aix_aux_prio u_prio
   (
      .aux(aux.prio)
   );

   // read multiplexer; unmapped addresses return zero
   function automatic logic [7:0] aix_read(input logic [7:0] addr,
                                           input aix_state_t s,
                                           input logic [7:0] raw,
                                           input logic [7:0] msk,
                                           input logic [3:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         ADDR_TCTL: v = s.tctl;
         ADDR_XFLG: v = {s.eflag, 4'h0};
         ADDR_AIPL: v = raw;
         ADDR_PIDX: v = {4'h0, idx};
         ADDR_AIEN: v = raw;
         ADDR_AIST: v = msk;
         ADDR_PIEN: v = s.pien;
         ADDR_PSEL: v = s.psel;
         ADDR_EICN: v = s.eicn;
         ADDR_EMSK: v = s.emsk;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // next state: software writes first, hardware sets afterwards
   // so an event in the clearing cycle is never lost
   always_comb
   begin
      logic [3:0] hit;
      logic fall0;
      logic fall1;
      hit = aix_edge(edge_in, st_reg.eprev);
      fall0 = st_reg.xprev[0] & ~ext_input_zero;
      fall1 = st_reg.xprev[1] & ~ext_input_one;
      st_next = st_reg;
      st_next.eprev = edge_in;
      st_next.xprev = {ext_input_one, ext_input_zero};

      // register writes
      if (sfr_wr)
      begin
         case (sfr_addr)
            ADDR_TCTL: st_next.tctl = sfr_wdata;
            // a one sets the flag, a zero clears it
            ADDR_XFLG: st_next.eflag = sfr_wdata[XFLG_LSB +: 4];
            ADDR_AIEN: st_next.aien = sfr_wdata;
            ADDR_PIEN: st_next.pien = sfr_wdata;
            ADDR_PSEL: st_next.psel = sfr_wdata;
            ADDR_EICN: st_next.eicn = sfr_wdata;
            ADDR_EMSK: st_next.emsk = sfr_wdata;
            default: st_next = st_next;
         endcase
      end

      // extra flags stay set until software clears them
      st_next.eflag = st_next.eflag | hit;

      // external inputs zero and one: edge or low level by type bit
      if (st_reg.tctl[TCTL_IT0])
      begin
         st_next.tctl[TCTL_IE0] = st_next.tctl[TCTL_IE0] | fall0;
      end
      else
      begin
         st_next.tctl[TCTL_IE0] = ~ext_input_zero;
      end
      if (st_reg.tctl[TCTL_IT1])
      begin
         st_next.tctl[TCTL_IE1] = st_next.tctl[TCTL_IE1] | fall1;
      end
      else
      begin
         st_next.tctl[TCTL_IE1] = ~ext_input_one;
      end
      st_next.tctl[TCTL_TF0] = st_next.tctl[TCTL_TF0] | tmr0_ovf;
      st_next.tctl[TCTL_TF1] = st_next.tctl[TCTL_TF1] | tmr1_ovf;

      // sticky summary and watchdog flags
      st_next.eicn[EICN_SUM] = st_next.eicn[EICN_SUM] | (|aux.masked);
      st_next.eicn[EICN_WDOG] = st_next.eicn[EICN_WDOG] | watchdog_evt;

      // requests use the state before this cycle's write
      st_next.aux_req = (|aux.masked) & st_reg.eicn[EICN_MEN];
      st_next.ext_req = st_reg.eflag & st_reg.emsk[3:0]
                        & {4{st_reg.pien[PIEN_GLOBAL]}};

      // read data is captured on the strobe and held until the next one
      if (sfr_rd)
      begin
         st_next.rdata = aix_read(sfr_addr, st_reg, aux.raw, aux.masked,
                                  aux.index);
      end
   end

   // single state register
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg.pien <= PIEN_RST;
         st_reg.psel <= PSEL_RST;
         st_reg.tctl <= TCTL_RST;
         st_reg.eicn <= EICN_RST;
         st_reg.emsk <= EMSK_RST;
         st_reg.aien <= AIEN_RST;
         st_reg.eflag <= 4'h0;
         st_reg.eprev <= EPRV_RST;
         st_reg.xprev <= XPRV_RST;
         st_reg.rdata <= 8'h00;
         st_reg.aux_req <= 1'b0;
         st_reg.ext_req <= 4'h0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register, except aux_vector, which is the constant AUX_VECTOR
   assign sfr_rdata = st_reg.rdata;
   assign ext_irq_req = st_reg.ext_req;
   assign aux_irq_req = st_reg.aux_req;
   assign aux_vector = AUX_VECTOR;
   assign prim_enable = st_reg.pien;
   assign priority_select = st_reg.psel;
   assign timer_run = {st_reg.tctl[TCTL_TR1], st_reg.tctl[TCTL_TR0]};
   assign serial1_dbl_rate = st_reg.eicn[EICN_SMOD1];

   // rising edge on input two sets its flag
   AST_EDGE_RISE: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (edge_in[0] && !$past(edge_in[0])) |=> st_reg.eflag[0])
      else $error("rising edge on input two did not set its flag");

   // falling edge on input three sets its flag
   AST_EDGE_FALL: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (!edge_in[1] && $past(edge_in[1])) |=> st_reg.eflag[1])
      else $error("falling edge on input three did not set its flag");

   // writing a one sets the flag
   AST_SW_SET: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (sfr_wr && sfr_addr == ADDR_XFLG && sfr_wdata[XFLG_LSB])
      |=> st_reg.eflag[0])
      else $error("software write did not set the extra flag");

   // a software-set flag raises its request when both masks allow
   AST_SW_REQ: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (sfr_wr && sfr_addr == ADDR_XFLG && sfr_wdata[XFLG_LSB + 2])
      ##1 (st_reg.emsk[2] && st_reg.pien[PIEN_GLOBAL])
      |=> ext_irq_req[2])
      else $error("software-set flag raised no request");

   // a set flag is never dropped without a software write
   AST_FLAG_HOLD: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (st_reg.eflag[2] && !(sfr_wr && sfr_addr == ADDR_XFLG))
      |=> st_reg.eflag[2])
      else $error("extra flag cleared without a write");

   // extra request follows flag, extended mask and global enable
   AST_EXT_REQ: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      ##1 ext_irq_req[3] == ($past(st_reg.eflag[3]) && $past(st_reg.emsk[3])
                             && $past(st_reg.pien[PIEN_GLOBAL])))
      else $error("extra request does not match flag and masks");

   // auxiliary request needs a masked pending source and master enable
   AST_AUX_REQ: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      ((|(aux_src & st_reg.aien)) && st_reg.eicn[EICN_MEN])
      |=> aux_irq_req)
      else $error("auxiliary request missing");

   // master enable clear keeps the auxiliary request low
   AST_AUX_MASTER: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !st_reg.eicn[EICN_MEN] |=> !aux_irq_req)
      else $error("auxiliary request while master enable clear");

   // index reads zero when nothing enabled is pending
   AST_PIDX_ZERO: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (sfr_rd && sfr_addr == ADDR_PIDX && (aux_src & st_reg.aien) == 8'h00)
      |=> sfr_rdata == 8'h00)
      else $error("pending index not zero with nothing pending");

   // masked status read returns raw and enable combined
   AST_MASK_READ: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (sfr_rd && sfr_addr == ADDR_AIST)
      |=> sfr_rdata == ($past(aux_src) & $past(st_reg.aien)))
      else $error("masked status read wrong");

   // enable read returns the raw status, not the written mask
   AST_AIEN_READ: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (sfr_rd && sfr_addr == ADDR_AIEN) |=> sfr_rdata == $past(aux_src))
      else $error("aux enable read did not return raw status");

   // primary enable reads back what was written
   AST_PIEN_READ: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (sfr_wr && sfr_addr == ADDR_PIEN) ##1 !sfr_wr ##1
      (sfr_rd && sfr_addr == ADDR_PIEN && !sfr_wr)
      |=> sfr_rdata == $past(sfr_wdata, 3))
      else $error("primary enable read-back mismatch");

   // watchdog event lands in the control register flag
   AST_WDT_SET: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      watchdog_evt |=> st_reg.eicn[EICN_WDOG])
      else $error("watchdog flag not set");

   // any masked pending source sets the summary flag
   AST_SUM_SET: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (|(aux_src & st_reg.aien)) |=> st_reg.eicn[EICN_SUM])
      else $error("auxiliary summary flag not set");

   // level mode: input zero flag follows the inverted pin
   AST_LVL_IN0: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !st_reg.tctl[TCTL_IT0]
      |=> st_reg.tctl[TCTL_IE0] == !$past(ext_input_zero))
      else $error("level-mode input zero flag wrong");

   // edge mode: a falling input zero sets its flag
   AST_EDGE_IN0: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (st_reg.tctl[TCTL_IT0] && $past(ext_input_zero) && !ext_input_zero)
      |=> st_reg.tctl[TCTL_IE0])
      else $error("edge-mode input zero flag not set");

   // timer one overflow lands in its flag
   AST_TF1_SET: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      tmr1_ovf |=> st_reg.tctl[TCTL_TF1])
      else $error("timer one overflow flag not set");

   // raw status read returns the sources before masking
   AST_RAW_READ: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (sfr_rd && sfr_addr == ADDR_AIPL) |=> sfr_rdata == $past(aux_src))
      else $error("raw status read wrong");

   // the seconds source outranks every other one
   AST_IDX_HIGH: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (sfr_rd && sfr_addr == ADDR_PIDX && aux_src[0] && st_reg.aien[0])
      |=> sfr_rdata == 8'h01)
      else $error("pending index missed the top source");
endmodule // aix_irq_ctrl

// [testbench/aix_core_model.sv]
module aix_core_model
(
   // clock
   sys_clk,
   // register port toward the device
   sfr_addr,
   sfr_wr,
   sfr_rd,
   sfr_wdata,
   sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import aix_pkg::*;
   input wire logic sys_clk;
   output logic [aix_pkg::SFR_AW-1:0] sfr_addr;
   output logic sfr_wr;
   output logic sfr_rd;
   output logic [aix_pkg::SFR_DW-1:0] sfr_wdata;
   input wire logic [aix_pkg::SFR_DW-1:0] sfr_rdata;

   // idle bus from time zero
   initial
   begin
      sfr_addr = 8'h00;
      sfr_wr = 1'h0;
      sfr_rd = 1'h0;
      sfr_wdata = 8'h00;
   end

   // one write per call; strobe held across exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'h1;
      @(negedge sys_clk);
      sfr_wr = 1'h0;
      // released lines show the inverse, so stale values never match
      sfr_wdata = ~d;
      sfr_addr = ~a;
   endtask

   // read data is registered, so it is taken one edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_rd = 1'h1;
      @(negedge sys_clk);
      sfr_rd = 1'h0;
      sfr_addr = ~a;
      @(negedge sys_clk);
      d = sfr_rdata;
   endtask

   // flag clearing is software's job: clear by writing zeros
   task automatic clear_flags();
      wr(ADDR_XFLG, 8'h00);
   endtask
endmodule // aix_core_model

// [testbench/aux_ext_interrupt_ctrl_tb.sv]
module aux_ext_interrupt_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import aix_pkg::*;
   logic sys_clk, rstn, sfr_wr, sfr_rd, tmr0_ovf;
   logic tmr1_ovf, ext_input_zero, ext_input_one, watchdog_evt;
   logic serial1_dbl_rate;
   logic [1:0] timer_run;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, aux_src, prim_enable, prio;
   logic [3:0] edge_in, ext_irq_req;
   logic aux_irq_req;
   logic [15:0] aux_vector;
   int mismatches = 0;
   int comparisons = 0;

   aix_irq_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .edge_in(edge_in),
      .ext_input_zero(ext_input_zero), .ext_input_one(ext_input_one),
      .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf),
      .watchdog_evt(watchdog_evt), .aux_src(aux_src),
      .ext_irq_req(ext_irq_req), .aux_irq_req(aux_irq_req),
      .aux_vector(aux_vector), .prim_enable(prim_enable),
      .priority_select(prio), .timer_run(timer_run),
      .serial1_dbl_rate(serial1_dbl_rate));

   aix_core_model core (.sys_clk(sys_clk), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata));

   // 100 ns period
   initial
   begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic close_out();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      core.rd(a, d);
      chk({8'h00, d}, {8'h00, e});
   endtask

   // events take two edges to reach the request outputs
   task automatic settle();
      repeat (3) @(negedge sys_clk);
   endtask

   // the whole run is under two hundred cycles; this cuts a hang short
   initial
   begin
      #500000;
      mismatches++;
      close_out();
   end

   initial
   begin
      // edge inputs at their idle levels so reset sees no edge
      edge_in = 4'h5;
      aux_src = 8'h00;
      tmr0_ovf = 1'h0;
      tmr1_ovf = 1'h0;
      watchdog_evt = 1'h0;
      ext_input_zero = 1'h1;
      ext_input_one = 1'h1;
      rstn = 1'h0;
      repeat (10) @(negedge sys_clk);
      rstn = 1'h1;
      rchk(ADDR_PIEN, 8'h00);
      rchk(ADDR_XFLG, 8'h00);
      rchk(ADDR_PIDX, 8'h00);
      rchk(8'h90, 8'h00);
      chk(aux_vector, 16'h0033);
      // primary enable and priority hold what was written
      core.wr(ADDR_PIEN, 8'h81);
      chk({8'h00, prim_enable}, 16'h0081);
      rchk(ADDR_PIEN, 8'h81);
      core.wr(ADDR_PSEL, 8'h55);
      rchk(ADDR_PSEL, 8'h55);
      chk({8'h00, prio}, 16'h0055);
      // timer overflow lands in timer control; level inputs idle high
      @(negedge sys_clk);
      tmr0_ovf = 1'h1;
      @(negedge sys_clk);
      tmr0_ovf = 1'h0;
      rchk(ADDR_TCTL, 8'h20);
      // level mode: a low input zero shows in its flag
      ext_input_zero = 1'h0;
      rchk(ADDR_TCTL, 8'h22);
      ext_input_zero = 1'h1;
      // edge mode on input zero, both timers run, overflow flag cleared
      core.wr(ADDR_TCTL, 8'h51);
      chk({14'h0000, timer_run}, 16'h0003);
      @(negedge sys_clk);
      ext_input_zero = 1'h0;
      ext_input_one = 1'h0;
      tmr1_ovf = 1'h1;
      @(negedge sys_clk);
      ext_input_zero = 1'h1;
      tmr1_ovf = 1'h0;
      rchk(ADDR_TCTL, 8'hDB);
      ext_input_one = 1'h1;
      // watchdog event and serial rate bit in the control register
      @(negedge sys_clk);
      watchdog_evt = 1'h1;
      @(negedge sys_clk);
      watchdog_evt = 1'h0;
      rchk(ADDR_EICN, 8'h08);
      core.wr(ADDR_EICN, 8'h80);
      chk({15'h0000, serial1_dbl_rate}, 16'h0001);
      core.wr(ADDR_EICN, 8'h00);
      // wrong-direction edges on inputs two, four and five leave the flags clear; input three does not change
      edge_in = 4'h8;
      settle();
      rchk(ADDR_XFLG, 8'h00);
      // rises on two and four, fall on five
      edge_in = 4'h7;
      settle();
      rchk(ADDR_XFLG, 8'hD0);
      // fall on three
      edge_in = 4'h5;
      settle();
      rchk(ADDR_XFLG, 8'hF0);
      repeat (5) @(negedge sys_clk);
      rchk(ADDR_XFLG, 8'hF0);
      core.clear_flags();
      rchk(ADDR_XFLG, 8'h00);
      // software-set flag raises a request only when both masks allow
      core.wr(ADDR_EMSK, 8'h04);
      core.wr(ADDR_XFLG, 8'h40);
      settle();
      chk({12'h000, ext_irq_req}, 16'h0004);
      core.wr(ADDR_PIEN, 8'h01);
      settle();
      chk({12'h000, ext_irq_req}, 16'h0000);
      core.clear_flags();
      // auxiliary sources, raw and masked views
      aux_src = 8'h28;
      rchk(ADDR_AIPL, 8'h28);
      rchk(ADDR_AIEN, 8'h28);
      rchk(ADDR_AIST, 8'h00);
      rchk(ADDR_PIDX, 8'h00);
      core.wr(ADDR_AIPL, 8'hFF);
      rchk(ADDR_AIPL, 8'h28);
      core.wr(ADDR_AIEN, 8'h20);
      rchk(ADDR_AIST, 8'h20);
      rchk(ADDR_PIDX, 8'h06);
      rchk(ADDR_AIEN, 8'h28);
      rchk(ADDR_EICN, 8'h10);
      chk({15'h0000, aux_irq_req}, 16'h0000);
      core.wr(ADDR_EICN, 8'h20);
      settle();
      chk({15'h0000, aux_irq_req}, 16'h0001);
      core.wr(ADDR_AIEN, 8'h08);
      rchk(ADDR_PIDX, 8'h04);
      core.wr(ADDR_AIEN, 8'h00);
      settle();
      chk({15'h0000, aux_irq_req}, 16'h0000);
      // each of the eight sources alone gives its own index
      core.wr(ADDR_AIEN, 8'hFF);
      for (int i = 0; i < AUX_N; i++)
      begin
         aux_src = 8'h01 << i;
         rchk(ADDR_PIDX, 8'(i + 1));
         chk({15'h0000, aux_irq_req}, 16'h0001);
      end
      aux_src = 8'hFF;
      rchk(ADDR_PIDX, 8'h01);
      core.wr(ADDR_EICN, 8'h00);
      settle();
      chk({15'h0000, aux_irq_req}, 16'h0000);
      // mid-run reset returns the registers to their idle values
      @(negedge sys_clk);
      rstn = 1'h0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'h1;
      rchk(ADDR_PIEN, 8'h00);
      rchk(ADDR_AIST, 8'h00);
      close_out();
   end
endmodule // aux_ext_interrupt_ctrl_tb
